// ===== common/psfm_pkg.sv
// Shared constants and types for the pulse and semi-period measurement channel.
package psfm_pkg;
   // Width of every measuring counter.
   localparam int CNT_W = 32;
   // Default depth of the measurement buffer.
   localparam int FIFO_DEPTH = 16;
   // Number of routable input pins; two-bit source fields select among them.
   localparam int PIN_W = 4;
   // Register offsets on the plain register port.
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_GATE = 8'h04;
   localparam logic [7:0] ADDR_PERIODS = 8'h08;
   localparam logic [7:0] ADDR_STATUS = 8'h0c;
   localparam logic [7:0] ADDR_DATA_A = 8'h10;
   localparam logic [7:0] ADDR_DATA_B = 8'h14;
   // Values after reset of the gate time and period count registers.
   localparam logic [31:0] GATE_RST = 32'h0000_2710;
   localparam logic [31:0] PER_RST = 32'h0000_0003;
   // Status register bit positions.
   localparam int ST_RUN = 0;
   localparam int ST_ARM = 1;
   localparam int ST_OVF = 2;
   localparam int ST_EMPTY = 3;
   localparam int ST_FULL = 4;
   localparam int ST_CFG = 5;
   localparam int ST_LVL = 6;
   // System clock and internal timebase rates in MHz.
   localparam int CLK_MHZ = 125;
   localparam int TB_MHZ = 100;
   // Phase accumulator step and wrap that derive the timebase tick.
   localparam logic [7:0] TB_STEP = 8'(TB_MHZ);
   localparam logic [7:0] TB_WRAP = 8'(CLK_MHZ);
   // Measurement kinds.
   typedef enum logic [2:0] {
      MODE_PULSE = 3'h0,
      MODE_SEMI = 3'h1,
      MODE_LOW1 = 3'h2,
      MODE_LARGE = 3'h3,
      MODE_HIGH = 3'h4
   } psfm_mode_type;
   // Timing kinds.
   typedef enum logic [1:0] {
      TIM_OND = 2'h0,
      TIM_IMPL = 2'h1,
      TIM_SCLK = 2'h2
   } psfm_timing_type;
   // Control register layout, most significant field first.
   typedef struct packed {
      logic [1:0] tb_src;
      logic [1:0] sclk_src;
      logic [1:0] arm_src;
      logic [1:0] sig_src;
      logic tb_ext;
      logic arm_fall;
      logic edge_fall;
      logic arm_en;
      psfm_timing_type timing;
      psfm_mode_type mode;
      logic run;
   } psfm_ctrl_type;
   localparam int CTRL_W = $bits(psfm_ctrl_type);
   localparam psfm_ctrl_type CTRL_RST = '0;
   // One buffered measurement: two raw result words, a and b.
   typedef struct packed {
      logic [CNT_W-1:0] a;
      logic [CNT_W-1:0] b;
   } psfm_sample_type;
   // Capture sequencer states, one-hot.
   typedef enum logic [5:0] {
      S_IDLE = 6'b000001,
      S_ARM = 6'b000010,
      S_SEEK = 6'b000100,
      S_PH1 = 6'b001000,
      S_PH2 = 6'b010000,
      S_HOLD = 6'b100000
   } psfm_state_type;
endpackage

// ===== core/psfm_sync.sv
// Three-stage input synchroniser with an agreement filter for pin inputs.
`timescale 1ns/100ps
module psfm_sync #(
   parameter int W = 4
) (
   // Clock and reset.
   input wire logic clock_i,
   input wire logic rst_n_i,
   // Asynchronous pins and their settled levels.
   input wire logic [W-1:0] async_i,
   output logic [W-1:0] level_o
);
   // One synchroniser chain per pin.
   for (genvar i = 0; i < W; i++) begin : g_bit
      logic s1_r;
      logic s2_r;
      logic s3_r;
      // The first stage feeds only the second; a change counts once stages two and three agree.
      always_ff @(posedge clock_i) begin
         if (!rst_n_i) begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
            s3_r <= 1'b0;
            level_o[i] <= 1'b0;
         end else begin
            s1_r <= async_i[i];
            s2_r <= s1_r;
            s3_r <= s2_r;
            if (s2_r == s3_r) begin
               level_o[i] <= s3_r;
            end
         end
      end
   end
endmodule

// ===== core/psfm_fifo.sv
// Measurement buffer memory with a registered head word.
`timescale 1ns/100ps
module psfm_fifo #(
   parameter int W = 64,
   parameter int DEPTH = 16
) (
   // Clock and reset.
   input wire logic clock_i,
   input wire logic rst_n_i,
   // Write side.
   input wire logic wr_i,
   input wire logic [W-1:0] wdata_i,
   // Read side; the head word is always shown.
   input wire logic rd_i,
   output logic [W-1:0] rdata_o,
   output logic empty_o,
   output logic full_o
);
   localparam int AW = $clog2(DEPTH);
   // Depth must be a power of two of at least two.
   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
      $error("psfm_fifo depth must be a power of two");
   end
   logic [W-1:0] mem_r [DEPTH];
   logic [AW-1:0] wp_r;
   logic [AW-1:0] rp_r;
   logic [AW:0] cnt_r;
   logic do_rd;
   logic do_wr;
   logic [AW-1:0] rp_nxt;
   // Full and empty come straight from the occupancy count.
   assign empty_o = (cnt_r == '0);
   assign full_o = (cnt_r == (AW+1)'(DEPTH));
   assign do_rd = rd_i && !empty_o;
   assign do_wr = wr_i && !full_o;
   assign rp_nxt = do_rd ? rp_r + 1'b1 : rp_r;
   // Storage is written without reset.
   always_ff @(posedge clock_i) begin
      if (do_wr) begin
         mem_r[wp_r] <= wdata_i;
      end
   end
   // Pointers and count.
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         wp_r <= '0;
         rp_r <= '0;
         cnt_r <= '0;
      end else begin
         wp_r <= do_wr ? wp_r + 1'b1 : wp_r;
         rp_r <= rp_nxt;
         cnt_r <= cnt_r + (AW+1)'(do_wr) - (AW+1)'(do_rd);
      end
   end
   // The head register bypasses a word written into the slot about to be shown.
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         rdata_o <= '0;
      end else if (do_wr && wp_r == rp_nxt) begin
         rdata_o <= wdata_i;
      end else begin
         rdata_o <= mem_r[rp_nxt];
      end
   end
endmodule

// ===== core/psfm_top.sv
// Pulse, semi-period and frequency measurement channel with register port and buffer.
//
// Summary of operation
// - Default start edge rising: high then low.
// - Starting edge selectable rising or falling.
// - On-demand captures first complete pulse, holds it.
// - On-demand ignores input while result held.
// - After host read, measure next pulse, repeat.
// - Implicit buffers every pulse's high and low.
// - Sample clock stores exactly one measurement per edge.
// - Stored value is latest pulse finished before.
// - Without arm trigger, start measuring on start.
// - Arm trigger waits for selected edge polarity.
// - Durations count selectable timebase, default 100 MHz.
// - Durations reported as raw timebase tick counts.
// - Semi-period and pulse share capture hardware.
// - Semi-period emits phases separately; pulse pairs.
// - Sample clock timing refused for semi-period.
// - Sample clock: low-frequency one result each; large-range and high-frequency refused.
// - Gate-time frequency result after gate elapses.
// - Period-count frequency result after N periods.
// - Low-frequency method measures one input period.
// - Large-range method: two counters over N periods.
// - High-frequency method: two counters, fixed time.
// - Measuring counters are thirty-two bits wide.
//
// The address-and-strobe port and the register offsets were chosen for this implementation.
`timescale 1ns/100ps
module psfm_top import psfm_pkg::*; #(
   parameter int CW = CNT_W,
   parameter int DEPTH = FIFO_DEPTH
) (
   // Clock and reset.
   input wire logic clock_i,
   input wire logic rst_n_i,
   // Register port.
   input wire logic [7:0] addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [31:0] rdata_o,
   // Routable input pins.
   input wire logic [PIN_W-1:0] programmable_function_input_i,
   // Channel activity.
   output logic running_o
);
   // The counters and the data path are fixed at the documented width.
   if (CW != 32) begin : g_chk
      $error("psfm_top counter width must be 32");
   end

   // Settled pin levels.
   logic [PIN_W-1:0] pin_lvl;
   // Control, gate time, period count and overflow registers.
   psfm_ctrl_type ctrl_r;
   logic [31:0] gate_r;
   logic [31:0] per_r;
   logic ovf_r;
   // Sequencer state.
   psfm_state_type st_r;
   // Previous levels for edge detection.
   logic sig_q_r;
   logic arm_q_r;
   logic sclk_q_r;
   logic tb_q_r;
   // Internal timebase phase accumulator.
   logic [7:0] tb_acc_r;
   // First and second phase durations of the pulse in progress.
   logic [CW-1:0] cnt1_r;
   logic [CW-1:0] cnt2_r;
   // Latest complete pulse.
   psfm_sample_type last_r;
   // Period counter and span counter of the two-counter methods.
   logic [CW-1:0] per_cnt_r;
   logic [CW-1:0] span_r;
   // Gate timer of the high-frequency method.
   logic [CW-1:0] gate_cnt_r;
   // Selected levels and their edges.
   logic sig_lvl;
   logic arm_lvl;
   logic sclk_lvl;
   logic tb_lvl;
   logic open_e;
   logic close_e;
   logic arm_e;
   logic sclk_e;
   logic tick;
   logic int_tick;
   // Sequencer events.
   logic measuring;
   logic hi_done;
   logic pulse_done;
   logic cfg_bad;
   logic hold_go;
   // Buffer traffic.
   logic push;
   psfm_sample_type pdata;
   psfm_sample_type head;
   logic fifo_empty;
   logic fifo_full;
   logic pop;
   // Register access decode.
   logic wr_ctrl;
   logic rd_b;

   // Pin inputs pass the three-stage synchroniser.
   psfm_sync #(.W(PIN_W)) u_sync (
      .clock_i(clock_i),
      .rst_n_i(rst_n_i),
      .async_i(programmable_function_input_i),
      .level_o(pin_lvl)
   );

   // Source routing of the measured signal, arm trigger, sample clock and timebase.
   assign sig_lvl = pin_lvl[ctrl_r.sig_src];
   assign arm_lvl = pin_lvl[ctrl_r.arm_src];
   assign sclk_lvl = pin_lvl[ctrl_r.sclk_src];
   assign tb_lvl = pin_lvl[ctrl_r.tb_src];

   // The starting edge opens each pulse; the opposite edge ends the first phase.
   assign open_e = ctrl_r.edge_fall ? (sig_q_r && !sig_lvl) : (!sig_q_r && sig_lvl);
   assign close_e = ctrl_r.edge_fall ? (!sig_q_r && sig_lvl) : (sig_q_r && !sig_lvl);
   assign arm_e = ctrl_r.arm_fall ? (arm_q_r && !arm_lvl) : (!arm_q_r && arm_lvl);
   assign sclk_e = !sclk_q_r && sclk_lvl;

   // Internal 100 MHz tick from the 125 MHz clock, or a rising pin edge.
   assign int_tick = (tb_acc_r + TB_STEP) >= TB_WRAP;
   assign tick = ctrl_r.tb_ext ? (!tb_q_r && tb_lvl) : int_tick;

   // Accumulator and edge history.
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         tb_acc_r <= '0;
         sig_q_r <= 1'b0;
         arm_q_r <= 1'b0;
         sclk_q_r <= 1'b0;
         tb_q_r <= 1'b0;
      end else begin
         // The accumulator wraps at the clock rate so ticks average the timebase rate.
         tb_acc_r <= int_tick ? tb_acc_r + TB_STEP - TB_WRAP : tb_acc_r + TB_STEP;
         sig_q_r <= sig_lvl;
         arm_q_r <= arm_lvl;
         sclk_q_r <= sclk_lvl;
         tb_q_r <= tb_lvl;
      end
   end

   // Configurations that the channel refuses to start with.
   always_comb begin
      cfg_bad = 1'b0;
      if (ctrl_r.mode == MODE_SEMI && ctrl_r.timing == TIM_SCLK) begin
         cfg_bad = 1'b1;
      end
      if ((ctrl_r.mode == MODE_LARGE || ctrl_r.mode == MODE_HIGH)
          && ctrl_r.timing == TIM_SCLK) begin
         cfg_bad = 1'b1;
      end
      if (ctrl_r.mode > MODE_HIGH || ctrl_r.timing > TIM_SCLK) begin
         cfg_bad = 1'b1;
      end
      if (per_r == '0 || gate_r == '0) begin
         cfg_bad = 1'b1;
      end
   end

   // Pulse milestones; a pulse counts only after both edges were seen.
   assign measuring = (st_r == S_SEEK) || (st_r == S_PH1) || (st_r == S_PH2);
   assign hi_done = (st_r == S_PH1) && close_e;
   assign pulse_done = (st_r == S_PH2) && open_e;

   // Result selection per measurement kind and timing.
   always_comb begin
      push = 1'b0;
      pdata = '0;
      if (ctrl_r.timing == TIM_SCLK && measuring) begin
         // One stored word per sample clock edge, taken from the latest complete pulse.
         push = sclk_e;
         if (ctrl_r.mode == MODE_LOW1) begin
            pdata.a = CW'(1);
            pdata.b = last_r.a + last_r.b;
         end else begin
            pdata = last_r;
         end
      end else begin
         unique case (ctrl_r.mode)
            MODE_PULSE: begin
               // The high and low phase of one pulse form one word.
               push = pulse_done;
               pdata.a = cnt1_r;
               pdata.b = cnt2_r;
            end
            MODE_SEMI: begin
               // Each phase is its own word; b marks the first phase.
               push = hi_done || pulse_done;
               pdata.a = hi_done ? cnt1_r : cnt2_r;
               pdata.b = CW'(hi_done);
            end
            MODE_LOW1: begin
               // One input period measured in ticks.
               push = pulse_done;
               pdata.a = CW'(1);
               pdata.b = cnt1_r + cnt2_r;
            end
            MODE_LARGE: begin
               // The period counter closes the span after the set number of periods.
               // Only a running span may close; idle, armed or held states never push.
               push = (st_r == S_PH1 || st_r == S_PH2) && open_e
                      && (per_cnt_r + CW'(1) == per_r);
               pdata.a = per_r;
               pdata.b = span_r;
            end
            MODE_HIGH: begin
               // The gate timer closes after the set time; periods seen are reported.
               push = measuring && (gate_cnt_r + CW'(tick) >= gate_r);
               pdata.a = per_cnt_r + CW'(open_e);
               pdata.b = gate_r;
            end
            default: begin
               push = 1'b0;
            end
         endcase
      end
   end

   // On-demand timing holds after each completed result, except a semi-period first phase.
   assign hold_go = (ctrl_r.timing == TIM_OND) && push
                    && !(ctrl_r.mode == MODE_SEMI && hi_done);

   // Capture sequencer.
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         st_r <= S_IDLE;
      end else if (!ctrl_r.run) begin
         st_r <= S_IDLE;
      end else begin
         unique case (st_r)
            S_IDLE: begin
               // Start at once unless an arm trigger is enabled.
               if (!cfg_bad) begin
                  st_r <= ctrl_r.arm_en ? S_ARM : S_SEEK;
               end
            end
            S_ARM: begin
               if (arm_e) begin
                  st_r <= S_SEEK;
               end
            end
            S_SEEK: begin
               // Partial pulses before the first starting edge are skipped.
               if (hold_go) begin
                  st_r <= S_HOLD;
               end else if (open_e) begin
                  st_r <= S_PH1;
               end
            end
            S_PH1: begin
               if (hold_go) begin
                  st_r <= S_HOLD;
               end else if (close_e) begin
                  st_r <= S_PH2;
               end
            end
            S_PH2: begin
               if (hold_go) begin
                  st_r <= S_HOLD;
               end else if (open_e) begin
                  st_r <= S_PH1;
               end
            end
            S_HOLD: begin
               // Input is ignored until the host has drained the result.
               if (fifo_empty) begin
                  st_r <= S_SEEK;
               end
            end
            default: begin
               st_r <= S_IDLE;
            end
         endcase
      end
   end

   // Phase counters and the latest complete pulse.
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         cnt1_r <= '0;
         cnt2_r <= '0;
         last_r <= '0;
      end else if (st_r == S_IDLE || st_r == S_ARM) begin
         // A pulse seen before measuring began is never reported later.
         cnt1_r <= '0;
         cnt2_r <= '0;
         last_r <= '0;
      end else if (st_r == S_SEEK || (st_r == S_PH2 && open_e)) begin
         cnt1_r <= '0;
         cnt2_r <= '0;
         if (pulse_done) begin
            last_r <= '{a: cnt1_r, b: cnt2_r};
         end
      end else if (st_r == S_PH1) begin
         cnt1_r <= cnt1_r + CW'(tick);
      end else if (st_r == S_PH2) begin
         cnt2_r <= cnt2_r + CW'(tick);
      end
   end

   // Period, span and gate counters of the frequency methods.
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         per_cnt_r <= '0;
         span_r <= '0;
         gate_cnt_r <= '0;
      end else if (!measuring) begin
         per_cnt_r <= '0;
         span_r <= '0;
         gate_cnt_r <= '0;
      end else if (ctrl_r.mode == MODE_HIGH) begin
         // The gate runs from the start; every starting edge inside it counts.
         gate_cnt_r <= push ? '0 : gate_cnt_r + CW'(tick);
         per_cnt_r <= push ? '0 : per_cnt_r + CW'(open_e);
      end else if (st_r != S_SEEK) begin
         // The span runs from the first starting edge over whole periods.
         per_cnt_r <= push ? '0 : per_cnt_r + CW'(open_e);
         span_r <= push ? CW'(tick) : span_r + CW'(tick);
      end
   end

   // Register port decode.
   assign wr_ctrl = wr_i && addr_i == ADDR_CTRL;
   assign rd_b = rd_i && addr_i == ADDR_DATA_B;
   assign pop = rd_b && !fifo_empty;

   // Control registers.
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         ctrl_r <= CTRL_RST;
         gate_r <= GATE_RST;
         per_r <= PER_RST;
      end else if (wr_i) begin
         if (wr_ctrl) begin
            ctrl_r <= psfm_ctrl_type'(wdata_i[CTRL_W-1:0]);
         end
         if (addr_i == ADDR_GATE) begin
            gate_r <= wdata_i;
         end
         if (addr_i == ADDR_PERIODS) begin
            per_r <= wdata_i;
         end
      end
   end

   // Overflow flag; a new overflow wins over a clear written in the same cycle.
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         ovf_r <= 1'b0;
      end else if (push && fifo_full) begin
         ovf_r <= 1'b1;
      end else if (wr_i && addr_i == ADDR_STATUS && wdata_i[ST_OVF]) begin
         ovf_r <= 1'b0;
      end
   end

   // Measurement buffer; a push into a full buffer is dropped inside it.
   psfm_fifo #(.W($bits(psfm_sample_type)), .DEPTH(DEPTH)) u_fifo (
      .clock_i(clock_i),
      .rst_n_i(rst_n_i),
      .wr_i(push),
      .wdata_i(pdata),
      .rd_i(pop),
      .rdata_o(head),
      .empty_o(fifo_empty),
      .full_o(fifo_full)
   );

   // Read data one cycle after the strobe; reading word b pops the head.
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         rdata_o <= '0;
      end else if (rd_i) begin
         unique case (addr_i)
            ADDR_CTRL: rdata_o <= 32'(ctrl_r);
            ADDR_GATE: rdata_o <= gate_r;
            ADDR_PERIODS: rdata_o <= per_r;
            ADDR_STATUS: begin
               rdata_o <= '0;
               rdata_o[ST_RUN] <= st_r != S_IDLE;
               rdata_o[ST_ARM] <= st_r == S_ARM;
               rdata_o[ST_OVF] <= ovf_r;
               rdata_o[ST_EMPTY] <= fifo_empty;
               rdata_o[ST_FULL] <= fifo_full;
               rdata_o[ST_CFG] <= cfg_bad;
               rdata_o[ST_LVL] <= sig_lvl;
            end
            ADDR_DATA_A: rdata_o <= fifo_empty ? '0 : head.a;
            ADDR_DATA_B: rdata_o <= fifo_empty ? '0 : head.b;
            default: rdata_o <= '0;
         endcase
      end else begin
         rdata_o <= '0;
      end
   end

   // Activity output.
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         running_o <= 1'b0;
      end else begin
         running_o <= st_r != S_IDLE;
      end
   end

   // Checks on the sequencer and the buffer path.
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rst_n_i);

   property p_rise_start;
      (st_r == S_SEEK && ctrl_r.run && !ctrl_r.edge_fall && !sig_q_r && sig_lvl
       && !hold_go) |=> (st_r == S_PH1);
   endproperty
   a_rise_start: assert property (p_rise_start) else $error("rising edge did not open");

   property p_fall_start;
      (st_r == S_SEEK && ctrl_r.run && ctrl_r.edge_fall && !sig_q_r && sig_lvl)
      |=> (st_r == S_SEEK);
   endproperty
   a_fall_start: assert property (p_fall_start) else $error("wrong edge opened");

   property p_hold_quiet;
      (st_r == S_HOLD) |-> !push;
   endproperty
   a_hold_quiet: assert property (p_hold_quiet) else $error("push while holding");

   property p_hold_release;
      (st_r == S_HOLD && ctrl_r.run && !fifo_empty) ##1 (fifo_empty && ctrl_r.run)
      |=> (st_r == S_SEEK);
   endproperty
   a_hold_release: assert property (p_hold_release) else $error("no resume after read");

   property p_ond_hold;
      (ctrl_r.run && ctrl_r.timing == TIM_OND && ctrl_r.mode == MODE_PULSE && pulse_done)
      |=> (st_r == S_HOLD) ##1 (st_r == S_HOLD || fifo_empty);
   endproperty
   a_ond_hold: assert property (p_ond_hold) else $error("result not held");

   property p_sclk_store;
      (ctrl_r.timing == TIM_SCLK && measuring && sclk_e)
      |-> (push && (pdata == last_r || ctrl_r.mode == MODE_LOW1)) ##1 !fifo_empty;
   endproperty
   a_sclk_store: assert property (p_sclk_store) else $error("sample clock not stored");

   property p_arm_wait;
      (st_r == S_ARM && ctrl_r.run && !arm_e) |=> (st_r == S_ARM);
   endproperty
   a_arm_wait: assert property (p_arm_wait) else $error("left arm wait early");

   property p_no_arm;
      (st_r == S_IDLE && ctrl_r.run && !cfg_bad && !ctrl_r.arm_en) |=> (st_r == S_SEEK);
   endproperty
   a_no_arm: assert property (p_no_arm) else $error("start did not begin");

   property p_semi_refused;
      (ctrl_r.run && ctrl_r.mode == MODE_SEMI && ctrl_r.timing == TIM_SCLK
       && st_r == S_IDLE) [*2] |-> (st_r == S_IDLE);
   endproperty
   a_semi_refused: assert property (p_semi_refused) else $error("semi with sample clock");

   property p_overflow;
      (push && fifo_full) |=> ovf_r && (fifo_full != $past(pop));
   endproperty
   a_overflow: assert property (p_overflow) else $error("overflow not flagged");
endmodule

// ===== testbench/psfm_pin_model.sv
// Pin model of the far side: pulse train, arm level and sample clock.
`timescale 1ns/100ps
module psfm_pin_model (
   // Clock and arm level from the bench.
   input wire logic clock_i,
   input wire logic arm_i,
   // Pins toward the channel.
   output logic [3:0] pins_o
);
   // Phase over a 50-cycle period: signal 20 high, 30 low.
   int unsigned ph = 0;
   // The period counter wraps so the pulse train runs free.
   always @(posedge clock_i) begin
      ph <= (ph == 49) ? 0 : ph + 1;
   end
   // The sample clock rises mid low phase; pin 3 is unused and pulled down.
   assign pins_o = {1'b0, (ph >= 30 && ph < 40), arm_i, (ph < 20)};
endmodule

// ===== testbench/psfm_top_tb_top.sv
// Self-checking bench for the measurement channel.
`timescale 1ns/100ps
module psfm_top_tb_top import psfm_pkg::*; ;
   logic clock_i = 0, rst_n_i = 0, wr_i = 0, rd_i = 0, arm = 0, running_o;
   logic [7:0] addr_i = 8'h0;
   logic [31:0] wdata_i = 32'h0, rdata_o, d, a;
   logic [3:0] pins;
   int fails = 0, n_checks = 0;
   // One row: mode, start edge, then bounds of word a and word b.
   typedef struct {psfm_mode_type m; logic ef; logic [31:0] alo, ahi, blo, bhi;} psfm_row_type;
   psfm_row_type rows [6] = '{'{MODE_PULSE, 1'b0, 32'he, 32'h12, 32'h16, 32'h1a},
      '{MODE_PULSE, 1'b1, 32'h16, 32'h1a, 32'he, 32'h12},
      '{MODE_SEMI, 1'b0, 32'he, 32'h12, 32'h1, 32'h1},
      '{MODE_LOW1, 1'b0, 32'h1, 32'h1, 32'h26, 32'h2a},
      '{MODE_LARGE, 1'b0, 32'h3, 32'h3, 32'h76, 32'h7a},
      '{MODE_HIGH, 1'b0, 32'hf8, 32'hfc, 32'h2710, 32'h2710}};
   psfm_top dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
      .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .programmable_function_input_i(pins),
      .running_o(running_o));
   psfm_pin_model pm (.clock_i(clock_i), .arm_i(arm), .pins_o(pins));
   initial forever #4 clock_i = ~clock_i;
   // Control word: arm on pin 1, sample clock on pin 2, signal on pin 0.
   function automatic logic [31:0] ctl(psfm_mode_type m, psfm_timing_type t, logic ef, logic ae);
      psfm_ctrl_type c;
      c = CTRL_RST;
      c.mode = m;
      c.timing = t;
      c.edge_fall = ef;
      c.arm_en = ae;
      c.arm_src = 2'h1;
      c.sclk_src = 2'h2;
      c.run = 1'b1;
      return 32'(c);
   endfunction
   // One-cycle write strobe.
   task automatic wr(input logic [7:0] ad, input logic [31:0] v);
      @(posedge clock_i);
      addr_i <= ad;
      wdata_i <= v;
      wr_i <= 1'b1;
      @(posedge clock_i);
      wr_i <= 1'b0;
   endtask
   // One-cycle read strobe; data is taken in the cycle after it.
   task automatic rd(input logic [7:0] ad);
      @(posedge clock_i);
      addr_i <= ad;
      rd_i <= 1'b1;
      @(posedge clock_i);
      rd_i <= 1'b0;
      #1 d = rdata_o;
   endtask
   // Range compare; an unknown never passes.
   task automatic chk(input string nm, input logic [31:0] lo, hi, got);
      n_checks++;
      if ((got >= lo && got <= hi) !== 1'b1) begin
         fails++;
         $display("wrong value %s expected %0d..%0d seen %0d", nm, lo, hi, got);
      end
   endtask
   // Polls the empty flag under a bounded count.
   task automatic wait_word();
      int k;
      k = 0;
      do begin
         rd(ADDR_STATUS);
         k++;
      end while (d[ST_EMPTY] !== 1'b0 && k < 9000);
      chk("ready", 32'h0, 32'h0, {31'h0, d[ST_EMPTY]});
   endtask
   // Pops one word into a and d.
   task automatic pop();
      rd(ADDR_DATA_A);
      a = d;
      rd(ADDR_DATA_B);
   endtask
   task automatic print_verdict();
      if (fails == 0 && n_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      repeat (2) @(posedge clock_i);
      rst_n_i <= 1'b1;
      rd(ADDR_GATE);
      chk("gate", GATE_RST, GATE_RST, d);
      rd(ADDR_PERIODS);
      chk("periods", PER_RST, PER_RST, d);
      rd(8'h40);
      chk("unmapped", 32'h0, 32'h0, d);
      // Ordinary cases: implicit timing, one row each.
      foreach (rows[i]) begin
         wr(ADDR_CTRL, ctl(rows[i].m, TIM_IMPL, rows[i].ef, 1'b0));
         wait_word();
         pop();
         chk("word a", rows[i].alo, rows[i].ahi, a);
         chk("word b", rows[i].blo, rows[i].bhi, d);
         wr(ADDR_CTRL, 32'h0);
         repeat (FIFO_DEPTH) rd(ADDR_DATA_B);
      end
      // Sample clock refused for semi-period.
      wr(ADDR_CTRL, ctl(MODE_SEMI, TIM_SCLK, 1'b0, 1'b0));
      repeat (4) rd(ADDR_STATUS);
      chk("refused", 32'h2, 32'h2, {30'h0, d[ST_CFG], running_o});
      // Sample clock pulse: the first word has no pulse yet, the third a whole one.
      wr(ADDR_CTRL, ctl(MODE_PULSE, TIM_SCLK, 1'b0, 1'b0));
      wait_word();
      pop();
      chk("sampled none", 32'h0, 32'h0, a);
      repeat (2) begin
         wait_word();
         pop();
      end
      chk("sampled high", 32'he, 32'h12, a);
      wr(ADDR_CTRL, 32'h0);
      repeat (FIFO_DEPTH) rd(ADDR_DATA_B);
      // On-demand: one word held while many pulses pass, then the next one.
      wr(ADDR_CTRL, ctl(MODE_PULSE, TIM_OND, 1'b0, 1'b0));
      repeat (400) @(posedge clock_i);
      pop();
      chk("held high", 32'he, 32'h12, a);
      rd(ADDR_STATUS);
      chk("held empty", 32'h1, 32'h1, {31'h0, d[ST_EMPTY]});
      wait_word();
      pop();
      chk("next high", 32'he, 32'h12, a);
      wr(ADDR_CTRL, 32'h0);
      repeat (FIFO_DEPTH) rd(ADDR_DATA_B);
      // Arm trigger withholds measuring, then the buffer overflows.
      wr(ADDR_CTRL, ctl(MODE_PULSE, TIM_IMPL, 1'b0, 1'b1));
      repeat (200) @(posedge clock_i);
      rd(ADDR_STATUS);
      chk("armed wait", 32'h3, 32'h3, {30'h0, d[ST_EMPTY], d[ST_ARM]});
      arm <= 1'b1;
      repeat (1200) @(posedge clock_i);
      rd(ADDR_STATUS);
      chk("overflow", 32'h3, 32'h3, {30'h0, d[ST_OVF], d[ST_FULL]});
      // Writing one to the overflow bit clears it once the channel is stopped.
      wr(ADDR_CTRL, 32'h0);
      wr(ADDR_STATUS, 32'h1 << ST_OVF);
      rd(ADDR_STATUS);
      chk("overflow clear", 32'h1, 32'h1, {30'h0, d[ST_OVF], d[ST_FULL]});
      // Falling arm polarity (control bit 8): a high arm level does not fire.
      wr(ADDR_CTRL, ctl(MODE_PULSE, TIM_IMPL, 1'b0, 1'b1) | 32'h100);
      repeat (20) @(posedge clock_i);
      rd(ADDR_STATUS);
      chk("armed fall", 32'h1, 32'h1, {31'h0, d[ST_ARM]});
      arm <= 1'b0;
      repeat (20) @(posedge clock_i);
      rd(ADDR_STATUS);
      chk("fired fall", 32'h0, 32'h0, {31'h0, d[ST_ARM]});
      // Reset in mid-run returns the channel to idle with an empty buffer.
      @(posedge clock_i);
      rst_n_i <= 1'b0;
      repeat (2) @(posedge clock_i);
      rst_n_i <= 1'b1;
      rd(ADDR_STATUS);
      chk("reset", 32'h8, 32'h8, {25'h0, running_o, d[5:0]});
      print_verdict();
   end
   initial begin
      repeat (60000) @(posedge clock_i);
      fails++;
      print_verdict();
   end
endmodule
